/* File: plds_pkg.sv */
// constants and types for pattern-lock and signal-absence status
//------------------------------------------------------------
//------------------------------------------------------------
package plds_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	// register offsets
	localparam logic [7:0] ALARM_STATE_ADDR = 8'h03;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h20;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h21;
	localparam logic [7:0] CONTROL_ADDR = 8'h22;
	// field positions
	localparam int unsigned ALM_PRBS_LOSS_BIT = 6;
	localparam int unsigned ALM_DLOS_BIT = 5;
	localparam int unsigned ALM_ALOS_BIT = 4;
	localparam int unsigned ALM_ABSENCE_BIT = 1;
	localparam int unsigned CTRL_CHK_EN_BIT = 0;
	localparam logic [7:0] EVENT_BITS = 8'h72;
	// reset values
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// digital detector
	localparam logic [7:0] DLOS_ZERO_LIMIT = 8'hA0;
	localparam int DLOS_WIN_BITS = 96;
	localparam int DLOS_DENS_PCT = 33;
	localparam logic [6:0] DLOS_WIN_LAST = 7'(DLOS_WIN_BITS - 1);
	localparam logic [6:0] DLOS_DENS_MIN =
		7'((DLOS_DENS_PCT * DLOS_WIN_BITS + 99) / 100);
	// analog detector levels
	localparam logic [7:0] ALOS_DECL_LVL = 8'h20;
	localparam logic [7:0] ALOS_CLR_LVL = 8'h30;
	// pattern checker
	localparam int unsigned PRBS_LEN = 15;
	localparam int unsigned PRBS_TAP_A = 14;
	localparam int unsigned PRBS_TAP_B = 13;
	localparam logic [9:0] PRBS_WIN_LAST = 10'h3FF;
	localparam logic [10:0] PRBS_DECL_ERRS = 11'h0C8;
	localparam logic [10:0] PRBS_CLR_ERRS = 11'h004;

	typedef enum logic [1:0] {
		LOCK_HELD = 2'b01,
		LOCK_LOST = 2'b10
	} plds_lock_state_t;
endpackage : plds_pkg

/* File: plds_line_if.sv */
// recovered line bit stream shared by the detectors
`timescale 1ns/100ps
interface plds_line_if;
	logic ce;
	logic bit_en;
	logic pulse;
	logic data;
	modport src (output ce, output bit_en, output pulse, output data);
	modport sink (input ce, input bit_en, input pulse, input data);
endinterface : plds_line_if

/* File: plds_prbs_chk.sv */
// receive pattern checker with windowed lock decision
`timescale 1ns/100ps
module plds_prbs_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic enable_i,
	plds_line_if.sink line,
	output logic lock_loss_o
);
	import plds_pkg::*;

	logic [PRBS_LEN-1:0] shift_reg;
	logic [9:0] win_cnt_reg;
	logic [10:0] err_cnt_reg;
	logic [10:0] err_total;
	logic bit_err;
	plds_lock_state_t state_reg;

	//------------------------------------------------------------
	// error detection
	//------------------------------------------------------------
	assign bit_err = line.data ^ shift_reg[PRBS_TAP_A] ^ shift_reg[PRBS_TAP_B];
	assign err_total = err_cnt_reg + {10'h000, bit_err};

	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !enable_i) begin
			shift_reg <= '0;
		end else if (line.ce && line.bit_en) begin
			shift_reg <= {shift_reg[PRBS_LEN-2:0], line.data};
		end
	end

	//------------------------------------------------------------
	// error window
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !enable_i) begin
			win_cnt_reg <= '0;
			err_cnt_reg <= '0;
		end else if (line.ce && line.bit_en) begin
			win_cnt_reg <= win_cnt_reg + 10'h001;
			if (win_cnt_reg == PRBS_WIN_LAST) begin
				err_cnt_reg <= '0;
			end else begin
				err_cnt_reg <= err_total;
			end
		end
	end

	//------------------------------------------------------------
	// lock state
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !enable_i) begin
			state_reg <= LOCK_HELD;
		end else if (line.ce && line.bit_en && win_cnt_reg == PRBS_WIN_LAST) begin
			case (state_reg)
				LOCK_HELD: begin
					if (err_total >= PRBS_DECL_ERRS) begin
						state_reg <= LOCK_LOST;
					end
				end
				LOCK_LOST: begin
					if (err_total <= PRBS_CLR_ERRS) begin
						state_reg <= LOCK_HELD;
					end
				end
				default: begin
					state_reg <= LOCK_HELD;
				end
			endcase
		end
	end

	assign lock_loss_o = (state_reg == LOCK_LOST);
endmodule : plds_prbs_chk

/* File: plds_dlos_det.sv */
// digital signal-absence detector on pulse-free run and density
`timescale 1ns/100ps
module plds_dlos_det (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	plds_line_if.sink line,
	output logic dlos_o
);
	import plds_pkg::*;

	logic [7:0] zero_cnt_reg;
	logic [7:0] zero_cnt_next;
	logic [6:0] win_cnt_reg;
	logic [6:0] ones_cnt_reg;
	logic [6:0] ones_total;
	logic dlos_reg;

	//------------------------------------------------------------
	// pulse-free run
	//------------------------------------------------------------
	always_comb begin
		zero_cnt_next = zero_cnt_reg;
		if (line.pulse) begin
			zero_cnt_next = '0;
		end else if (zero_cnt_reg != DLOS_ZERO_LIMIT) begin
			zero_cnt_next = zero_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			zero_cnt_reg <= '0;
		end else if (line.ce && line.bit_en) begin
			zero_cnt_reg <= zero_cnt_next;
		end
	end

	//------------------------------------------------------------
	// density window
	//------------------------------------------------------------
	assign ones_total = ones_cnt_reg + {6'h00, line.pulse};

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			win_cnt_reg <= '0;
			ones_cnt_reg <= '0;
		end else if (line.ce && line.bit_en) begin
			if (win_cnt_reg == DLOS_WIN_LAST) begin
				win_cnt_reg <= '0;
				ones_cnt_reg <= '0;
			end else begin
				win_cnt_reg <= win_cnt_reg + 7'h01;
				ones_cnt_reg <= ones_total;
			end
		end
	end

	//------------------------------------------------------------
	// declare and clear
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			dlos_reg <= 1'b0;
		end else if (line.ce && line.bit_en) begin
			if (zero_cnt_next == DLOS_ZERO_LIMIT) begin
				dlos_reg <= 1'b1;
			end else if (win_cnt_reg == DLOS_WIN_LAST
				&& ones_total >= DLOS_DENS_MIN) begin
				dlos_reg <= 1'b0;
			end
		end
	end

	assign dlos_o = dlos_reg;
endmodule : plds_dlos_det

/* File: plds_top.sv */
// per-channel alarm status: pattern lock loss and signal absence
`timescale 1ns/100ps
module plds_top (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [plds_pkg::ADDR_W-1:0] addr_i,
	input wire logic [plds_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [plds_pkg::DATA_W-1:0] rdata_o,
	output logic irq_o,
	input wire logic rx_bit_en_i,
	input wire logic rx_pulse_i,
	input wire logic rx_data_i,
	input wire logic [7:0] amp_level_i,
	output logic signal_absence_o,
	output logic pattern_lock_loss_o
);
	import plds_pkg::*;

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	logic [DATA_W-1:0] alarm_reg;
	logic [DATA_W-1:0] alarm_next;
	logic [DATA_W-1:0] irq_status_reg;
	logic [DATA_W-1:0] irq_mask_reg;
	logic [DATA_W-1:0] control_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] change_evt;
	logic [DATA_W-1:0] status_clr;
	logic irq_reg;
	logic alos_reg;
	logic absence_reg;
	logic lock_loss_reg;
	logic prbs_loss;
	logic dlos;
	logic chk_en;
	logic wr_hit_status;
	logic wr_hit_mask;
	logic wr_hit_ctrl;

	//------------------------------------------------------------
	// line stream to the detectors
	//------------------------------------------------------------
	plds_line_if line_bus ();

	assign line_bus.ce = ce_i;
	assign line_bus.bit_en = rx_bit_en_i;
	assign line_bus.pulse = rx_pulse_i;
	assign line_bus.data = rx_data_i;

	assign chk_en = control_reg[CTRL_CHK_EN_BIT];

	plds_prbs_chk u_prbs_chk (
		.clk_sys_i (clk_sys_i),
		.reset_i (reset_i),
		.enable_i (chk_en),
		.line (line_bus.sink),
		.lock_loss_o (prbs_loss)
	);

	plds_dlos_det u_dlos_det (
		.clk_sys_i (clk_sys_i),
		.reset_i (reset_i),
		.line (line_bus.sink),
		.dlos_o (dlos)
	);

	//------------------------------------------------------------
	// analog detector with hysteresis
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			alos_reg <= 1'b0;
		end else if (ce_i) begin
			if (!alos_reg && amp_level_i < ALOS_DECL_LVL) begin
				alos_reg <= 1'b1;
			end else if (alos_reg && amp_level_i > ALOS_CLR_LVL) begin
				alos_reg <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------
	// combined signal absence
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			absence_reg <= 1'b0;
		end else if (ce_i) begin
			absence_reg <= alos_reg | dlos;
		end
	end

	assign signal_absence_o = absence_reg;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lock_loss_reg <= 1'b0;
		end else if (ce_i) begin
			lock_loss_reg <= prbs_loss;
		end
	end

	assign pattern_lock_loss_o = lock_loss_reg;

	//------------------------------------------------------------
	// alarm status register
	//------------------------------------------------------------
	always_comb begin
		alarm_next = ALARM_RESET;
		alarm_next[ALM_PRBS_LOSS_BIT] = prbs_loss;
		alarm_next[ALM_DLOS_BIT] = dlos;
		alarm_next[ALM_ALOS_BIT] = alos_reg;
		alarm_next[ALM_ABSENCE_BIT] = alos_reg | dlos;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			alarm_reg <= ALARM_RESET;
		end else if (ce_i) begin
			alarm_reg <= alarm_next;
		end
	end

	//------------------------------------------------------------
	// write decode
	//------------------------------------------------------------
	always_comb begin
		wr_hit_status = 1'b0;
		wr_hit_mask = 1'b0;
		wr_hit_ctrl = 1'b0;
		if (!wr_i) begin
			wr_hit_status = 1'b0;
		end else if (addr_i == IRQ_STATUS_ADDR) begin
			wr_hit_status = 1'b1;
		end else if (addr_i == IRQ_MASK_ADDR) begin
			wr_hit_mask = 1'b1;
		end else if (addr_i == CONTROL_ADDR) begin
			wr_hit_ctrl = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (ce_i && wr_hit_mask) begin
			irq_mask_reg <= wdata_i & EVENT_BITS;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			control_reg <= CONTROL_RESET;
		end else if (ce_i && wr_hit_ctrl) begin
			control_reg <= wdata_i;
		end
	end

	//------------------------------------------------------------
	// change events and sticky status
	//------------------------------------------------------------
	assign change_evt = (alarm_next ^ alarm_reg) & EVENT_BITS;
	assign status_clr = wr_hit_status ? wdata_i : 8'h00;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_status_reg <= IRQ_STATUS_RESET;
		end else if (ce_i) begin
			irq_status_reg <= (irq_status_reg & ~status_clr) | change_evt;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			irq_reg <= |(irq_status_reg & irq_mask_reg);
		end
	end

	assign irq_o = irq_reg;

	//------------------------------------------------------------
	// read path
	//------------------------------------------------------------
	always_comb begin
		rdata_next = 8'h00;
		if (addr_i == ALARM_STATE_ADDR) begin
			rdata_next = alarm_reg;
		end else if (addr_i == IRQ_STATUS_ADDR) begin
			rdata_next = irq_status_reg;
		end else if (addr_i == IRQ_MASK_ADDR) begin
			rdata_next = irq_mask_reg;
		end else if (addr_i == CONTROL_ADDR) begin
			rdata_next = control_reg;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rdata_reg <= 8'h00;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rdata_next : 8'h00;
		end
	end

	assign rdata_o = rdata_reg;
endmodule : plds_top

/* File: plds_sva.sv */
// checker for the alarm status block ports
`timescale 1ns/100ps
module plds_sva (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic irq_o,
	input wire logic rx_bit_en_i,
	input wire logic rx_pulse_i,
	input wire logic rx_data_i,
	input wire logic [7:0] amp_level_i,
	input wire logic signal_absence_o,
	input wire logic pattern_lock_loss_o
);
	import plds_pkg::*;
	//----
	// pulse-free run counter
	//----
	logic [8:0] zrun_reg;
	always_ff @(posedge clk_sys_i) begin
		if (reset_i)
			zrun_reg <= 9'h000;
		else if (ce_i && rx_bit_en_i && (rx_pulse_i || zrun_reg != 9'h1FF))
			zrun_reg <= rx_pulse_i ? 9'h000 : zrun_reg + 9'h001;
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	//----
	// assertions
	//----
	chk_reset_quiet: assert property ($past(reset_i) |->
		rdata_o == 8'h00 && !irq_o && !signal_absence_o && !pattern_lock_loss_o)
		else $error("outputs not cleared by reset");
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read slot");
	chk_unmapped_zero: assert property (rd_i && addr_i == 8'h40 |=>
		rdata_o == 8'h00) else $error("unmapped read not zero");
	chk_alarm_spare: assert property (rd_i && addr_i == ALARM_STATE_ADDR |=>
		(rdata_o & 8'h8D) == 8'h00) else $error("spare alarm bits set");
	chk_absence_or: assert property (rd_i && addr_i == ALARM_STATE_ADDR |=>
		rdata_o[1] == (rdata_o[5] | rdata_o[4])) else $error("bit1 not OR");
	chk_out_match: assert property (rd_i && addr_i == ALARM_STATE_ADDR |=>
		rdata_o[6] == $past(pattern_lock_loss_o) &&
		rdata_o[1] == $past(signal_absence_o))
		else $error("alarm read differs from outputs");
	chk_dlos_declare: assert property (zrun_reg >= 9'd160 |->
		##2 signal_absence_o) else $error("no absence after 160 bits");
	chk_alos_declare: assert property (amp_level_i < ALOS_DECL_LVL |->
		##[1:3] signal_absence_o) else $error("no absence at low amplitude");
	cover property (zrun_reg == 9'd160);
	cover property ($rose(pattern_lock_loss_o));
	cover property (irq_o && rd_i);
endmodule : plds_sva

bind plds_top plds_sva plds_sva_i (.*);

/* File: plds_top_tb_top.sv */
// self-checking bench for the alarm status block
`timescale 1ns/100ps
module plds_top_tb_top;
	import plds_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic ce = 1'b1;
	logic bit_en = 1'b0;
	logic pulse = 1'b0;
	logic data = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] amp = 8'h80;
	logic [7:0] rdata;
	logic irq;
	logic absence;
	logic lock_loss;
	int num_errors = 0;
	int total_checks = 0;
	int nbits = 0;
	logic [31:0] rng = 32'h0000B490;
	logic [14:0] prbs = 15'h7FFF;
	logic [7:0] amps [5] = '{8'h20, 8'h1F, 8'h30, 8'h31, 8'h1F};
	logic [0:4] alos = 5'b01101;
	always #12.5 clk_sys_i = ~clk_sys_i;
	plds_top plds_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata), .irq_o(irq), .rx_bit_en_i(bit_en),
		.rx_pulse_i(pulse), .rx_data_i(data), .amp_level_i(amp),
		.signal_absence_o(absence), .pattern_lock_loss_o(lock_loss));
	//----
	// helpers
	//----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic [7:0] alm(input logic l, input logic d,
		input logic a);
		return {1'b0, l, d, a, 2'b00, d | a, 1'b0};
	endfunction : alm
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		// idle edge so a following write never reassigns the strobe
		@(posedge clk_sys_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		// read data stand for this one cycle only
		@(negedge clk_sys_i);
		cmp(rdata, exp);
		@(posedge clk_sys_i);
	endtask : rd
	// p: 0 no pulse, 1 pulse, 2 random; rnd picks random data over pattern
	task automatic sendb(input int n, input logic [1:0] p, input logic rnd);
		for (int i = 0; i < n; i++) begin
			rng = xs(rng);
			prbs = {prbs[13:0], prbs[14] ^ prbs[13]};
			bit_en <= 1'b1;
			pulse <= p[1] ? rng[1] : p[0];
			data <= rnd ? rng[0] : prbs[0];
			amp <= {1'b1, rng[14:8]};
			@(posedge clk_sys_i);
			bit_en <= 1'b0;
			@(posedge clk_sys_i);
			nbits++;
		end
	endtask : sendb
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		num_errors++;
		final_report();
	end
	//----
	// main sequence
	//----
	initial begin
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(ALARM_STATE_ADDR, ALARM_RESET);
		rd(IRQ_STATUS_ADDR, 8'h00);
		rd(CONTROL_ADDR, 8'h00);
		rd(8'h40, 8'h00);
		wr(ALARM_STATE_ADDR, 8'hFF);
		rd(ALARM_STATE_ADDR, 8'h00);
		wr(IRQ_MASK_ADDR, 8'hFF);
		rd(IRQ_MASK_ADDR, EVENT_BITS);
		// clock enable low freezes the registers
		ce <= 1'b0;
		wr(IRQ_MASK_ADDR, 8'h00);
		ce <= 1'b1;
		rd(IRQ_MASK_ADDR, EVENT_BITS);
		// pulse-free run at 159 and 160 bits
		sendb(300, 2'd2, 1'b1);
		sendb(1, 2'd1, 1'b0);
		sendb(159, 2'd0, 1'b0);
		rd(ALARM_STATE_ADDR, alm(0, 0, 0));
		sendb(1, 2'd0, 1'b0);
		rd(ALARM_STATE_ADDR, alm(0, 1, 0));
		cmp({7'h00, absence}, 8'h01);
		cmp({7'h00, irq}, 8'h01);
		rd(IRQ_STATUS_ADDR, 8'h22);
		wr(IRQ_STATUS_ADDR, 8'h22);
		rd(IRQ_STATUS_ADDR, 8'h00);
		cmp({7'h00, irq}, 8'h00);
		// density windows of 31 then 32 pulses
		sendb((96 - nbits % 96) % 96, 2'd0, 1'b0);
		sendb(31, 2'd1, 1'b0);
		sendb(65, 2'd0, 1'b0);
		rd(ALARM_STATE_ADDR, alm(0, 1, 0));
		sendb(32, 2'd1, 1'b0);
		sendb(64, 2'd0, 1'b0);
		rd(ALARM_STATE_ADDR, alm(0, 0, 0));
		// amplitude thresholds and interrupt masking
		wr(IRQ_STATUS_ADDR, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			amp <= amps[i];
			repeat (3) @(posedge clk_sys_i);
			rd(ALARM_STATE_ADDR, alm(0, 0, alos[i]));
		end
		rd(IRQ_STATUS_ADDR, 8'h12);
		cmp({7'h00, irq}, 8'h01);
		wr(IRQ_MASK_ADDR, 8'h00);
		rd(IRQ_STATUS_ADDR, 8'h12);
		cmp({7'h00, irq}, 8'h00);
		wr(IRQ_STATUS_ADDR, 8'h12);
		rd(IRQ_STATUS_ADDR, 8'h00);
		wr(IRQ_MASK_ADDR, EVENT_BITS);
		// pattern checker lock loss and recovery
		wr(CONTROL_ADDR, 8'h01);
		rd(CONTROL_ADDR, 8'h01);
		sendb(1024, 2'd1, 1'b1);
		rd(ALARM_STATE_ADDR, alm(1, 0, 0));
		cmp({7'h00, lock_loss}, 8'h01);
		sendb(2048, 2'd1, 1'b0);
		rd(ALARM_STATE_ADDR, alm(0, 0, 0));
		cmp({7'h00, lock_loss}, 8'h00);
		sendb(1024, 2'd1, 1'b1);
		@(posedge clk_sys_i);
		cmp({7'h00, lock_loss}, 8'h01);
		wr(CONTROL_ADDR, 8'h00);
		repeat (2) @(posedge clk_sys_i);
		rd(ALARM_STATE_ADDR, 8'h00);
		cmp({7'h00, lock_loss}, 8'h00);
		// reset in mid-run
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rd(IRQ_MASK_ADDR, IRQ_MASK_RESET);
		rd(IRQ_STATUS_ADDR, IRQ_STATUS_RESET);
		rd(ALARM_STATE_ADDR, ALARM_RESET);
		final_report();
	end
endmodule : plds_top_tb_top
